// *** hw/pfc_cfg.svh ***
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH

// ==========================================
// register offsets
`define PFC_ADDR_PIN1      6'h01
`define PFC_ADDR_PIN0      6'h02
`define PFC_ADDR_THR       6'h03

// ==========================================
// reset values
`define PFC_PIN1_RST       8'h2e
`define PFC_PIN0_RST       8'h3f
`define PFC_THR_RST        8'h07

// ==========================================
// field positions
`define PFC_DS_BIT         7
`define PFC_INV_BIT        6
`define PFC_RET_BIT        6

// ==========================================
// function codes
`define PFC_FN_HIZ         6'h2e
`define PFC_FN_XDIV        6'h3f
`define PFC_FN_RXTHR       6'h00
`define PFC_FN_TXTHR       6'h02

// ==========================================
// wake-up test settings
`define PFC_TEST_SETTING_ONE_RET0     8'h31
`define PFC_TEST_SETTING_TWO_RET0     8'h88
`define PFC_TEST_SETTING_ONE_RET1     8'h35
`define PFC_TEST_SETTING_TWO_RET1     8'h81

// ==========================================
// thresholds and timing
`define PFC_RX_STEP        7'h04
`define PFC_TX_BASE        7'h3d
`define PFC_XDIV_RATIO     192
`define PFC_XDIV_HALF      7'((`PFC_XDIV_RATIO) / 2)

`endif

// *** hw/pfc_pkg.sv ***
package pfc_pkg;
  typedef logic [7:0] pfc_byte_t;
  typedef logic [6:0] pfc_cnt_t;
  typedef logic [5:0] pfc_addr_t;
  typedef enum logic [1:0] {
    PFC_HIZ  = 2'b00,
    PFC_XDIV = 2'b01,
    PFC_SIG  = 2'b10
  } pfc_mode_t;
endpackage : pfc_pkg

// *** hw/pfc_thr_if.sv ***
`timescale 1ns/100ps
interface pfc_thr_if;
  logic [3:0]         sel;
  pfc_pkg::pfc_cnt_t  rx_bytes;
  pfc_pkg::pfc_cnt_t  tx_bytes;
  logic               rx_hit;
  logic               tx_hit;
  modport calc (input sel, input rx_bytes, input tx_bytes, output rx_hit, output tx_hit);
  modport user (output sel, output rx_bytes, output tx_bytes, input rx_hit, input tx_hit);
endinterface : pfc_thr_if

// *** hw/pfc_thresh.sv ***
`timescale 1ns/100ps
`include "pfc_cfg.svh"
module pfc_thresh (
  // threshold compare
  pfc_thr_if.calc thr
);
  import pfc_pkg::*;

  pfc_cnt_t rx_level;
  pfc_cnt_t tx_level;

  // ==========================================
  // level compare
  always_comb begin
    rx_level   = 7'((7'(thr.sel) + 7'h01) * `PFC_RX_STEP);  // [R07]
    tx_level   = 7'(`PFC_TX_BASE - 7'(7'(thr.sel) * `PFC_RX_STEP));  // [R08]
    thr.rx_hit = (thr.rx_bytes >= rx_level);  // [R07]
    thr.tx_hit = (thr.tx_bytes >= tx_level);  // [R08]
  end
endmodule : pfc_thresh

// *** hw/pfc_top.sv ***
// How it works
// R01 - Bit 6 of each pin register inverts that pin's selected signal when one.
// R02 - Pin 1 function field resets to 0x2e, which leaves the pin undriven.
// R03 - Pin 0 function field resets to 0x3f, which drives the clock divided by 192.
// R04 - The host is expected to turn the divided clock off at initialization.
// R05 - Bit 7 of the pin 1 register sets the drive strength of both pins.
// R06 - On wake the test settings become 0x31/0x88 or 0x35/0x81 by the retain bit.
// R07 - The RX threshold is 4*(setting+1) bytes, hit when the count is at or above it.
// R08 - The TX threshold is 61-4*setting bytes, hit when the count is at or above it.
`timescale 1ns/100ps
`include "pfc_cfg.svh"
module pfc_top (
  // clock, reset, enable
  input  wire logic                CLOCK,
  input  wire logic                RST_B,
  input  wire logic                CE,
  // register port
  input  wire pfc_pkg::pfc_addr_t  REG_ADDR,
  input  wire logic                REG_WR,
  input  wire logic                REG_RD,
  input  wire pfc_pkg::pfc_byte_t  REG_WDATA,
  output      pfc_pkg::pfc_byte_t  REG_RDATA,
  // fifo levels and wake
  input  wire pfc_pkg::pfc_cnt_t   RX_BYTES,
  input  wire pfc_pkg::pfc_cnt_t   TX_BYTES,
  input  wire logic                WAKE,
  // output pins
  output      logic [1:0]          PIN_OUT,
  output      logic [1:0]          PIN_OE,
  output      logic                PIN_DS,
  // status and analog settings
  output      logic                RX_THR_HIT,
  output      logic                TX_THR_HIT,
  output      pfc_pkg::pfc_byte_t  TEST_SETTING_ONE_VAL,
  output      pfc_pkg::pfc_byte_t  TEST_SETTING_TWO_VAL
);
  import pfc_pkg::*;

  pfc_byte_t  pin_cfg_r [2];
  pfc_byte_t  pin_cfg_nxt [2];
  pfc_byte_t  thr_cfg_r;
  pfc_byte_t  thr_cfg_nxt;
  pfc_byte_t  rdata_r;
  pfc_byte_t  rdata_nxt;
  pfc_byte_t  test_setting_one_r;
  pfc_byte_t  test_setting_one_nxt;
  pfc_byte_t  test_setting_two_r;
  pfc_byte_t  test_setting_two_nxt;
  pfc_cnt_t   xdiv_cnt_r;
  pfc_cnt_t   xdiv_cnt_nxt;
  logic       xclk_r;
  logic       xclk_nxt;
  logic [1:0] out_r;
  logic [1:0] oe_r;
  logic       out_nxt [2];
  logic       oe_nxt [2];
  logic       ds_r;
  logic       rxh_r;
  logic       txh_r;

  pfc_thr_if thr_bus ();

  // ==========================================
  // threshold compare
  assign thr_bus.sel      = thr_cfg_r[3:0];
  assign thr_bus.rx_bytes = RX_BYTES;
  assign thr_bus.tx_bytes = TX_BYTES;

  pfc_thresh u_thresh (
    .thr (thr_bus.calc)
  );

  // ==========================================
  // register file
  // unmapped writes are dropped, unmapped reads give zero
  always_comb begin
    pin_cfg_nxt = pin_cfg_r;
    thr_cfg_nxt = thr_cfg_r;
    rdata_nxt   = rdata_r;
    if (REG_WR) begin
      case (REG_ADDR)
        `PFC_ADDR_PIN1: pin_cfg_nxt[1] = REG_WDATA;
        `PFC_ADDR_PIN0: pin_cfg_nxt[0] = REG_WDATA;
        `PFC_ADDR_THR:  thr_cfg_nxt    = REG_WDATA;
        default: ;
      endcase
    end
    if (REG_RD) begin
      case (REG_ADDR)
        `PFC_ADDR_PIN1: rdata_nxt = pin_cfg_r[1];
        `PFC_ADDR_PIN0: rdata_nxt = pin_cfg_r[0];
        `PFC_ADDR_THR:  rdata_nxt = thr_cfg_r;
        default:        rdata_nxt = 8'h00;
      endcase
    end
  end

  // ==========================================
  // wake-up test settings
  // only the applied values change; test register reads are outside this block
  always_comb begin
    test_setting_one_nxt = test_setting_one_r;
    test_setting_two_nxt = test_setting_two_r;
    if (WAKE) begin
      test_setting_one_nxt = thr_cfg_r[`PFC_RET_BIT] ? `PFC_TEST_SETTING_ONE_RET1 : `PFC_TEST_SETTING_ONE_RET0;  // [R06]
      test_setting_two_nxt = thr_cfg_r[`PFC_RET_BIT] ? `PFC_TEST_SETTING_TWO_RET1 : `PFC_TEST_SETTING_TWO_RET0;  // [R06]
    end
  end

  // ==========================================
  // clock divider, CLOCK stands in for the crystal clock
  always_comb begin
    xdiv_cnt_nxt = 7'(xdiv_cnt_r + 7'h01);
    xclk_nxt     = xclk_r;
    if (xdiv_cnt_r == 7'(`PFC_XDIV_HALF - 7'h01)) begin
      xdiv_cnt_nxt = 7'h00;
      xclk_nxt     = ~xclk_r;  // [R03]
    end
  end

  // ==========================================
  // per-pin function select
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      pfc_mode_t mode;
      logic      sig;
      always_comb begin
        case (pin_cfg_r[gi][5:0])
          `PFC_FN_HIZ:  mode = PFC_HIZ;  // [R02]
          `PFC_FN_XDIV: mode = PFC_XDIV;  // [R03]
          default:      mode = PFC_SIG;
        endcase
        case (pin_cfg_r[gi][5:0])
          `PFC_FN_RXTHR: sig = rxh_r;
          `PFC_FN_TXTHR: sig = txh_r;
          default:       sig = 1'b0;
        endcase
        case (mode)
          PFC_HIZ:  sig = 1'b0;
          PFC_XDIV: sig = xclk_r;
          PFC_SIG:  sig = sig;
          default:  sig = 1'b0;
        endcase
        out_nxt[gi] = sig ^ pin_cfg_r[gi][`PFC_INV_BIT];  // [R01]
        oe_nxt[gi]  = (mode != PFC_HIZ);  // [R02]
      end
    end
  endgenerate

  // ==========================================
  // state registers
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      pin_cfg_r[1] <= `PFC_PIN1_RST;  // [R02]
      pin_cfg_r[0] <= `PFC_PIN0_RST;  // [R03]
      thr_cfg_r    <= `PFC_THR_RST;  // [R07]
      rdata_r      <= 8'h00;
      test_setting_one_r      <= `PFC_TEST_SETTING_ONE_RET0;
      test_setting_two_r      <= `PFC_TEST_SETTING_TWO_RET0;
      xdiv_cnt_r   <= 7'h00;
      xclk_r       <= 1'b0;
      out_r        <= 2'h0;
      oe_r         <= 2'h0;
      ds_r         <= 1'b0;
      rxh_r        <= 1'b0;
      txh_r        <= 1'b0;
    end else if (CE) begin
      pin_cfg_r  <= pin_cfg_nxt;
      thr_cfg_r  <= thr_cfg_nxt;
      rdata_r    <= rdata_nxt;
      test_setting_one_r    <= test_setting_one_nxt;
      test_setting_two_r    <= test_setting_two_nxt;
      xdiv_cnt_r <= xdiv_cnt_nxt;
      xclk_r     <= xclk_nxt;
      out_r      <= {out_nxt[1], out_nxt[0]};
      oe_r       <= {oe_nxt[1], oe_nxt[0]};
      ds_r       <= pin_cfg_r[1][`PFC_DS_BIT];  // [R05]
      rxh_r      <= thr_bus.rx_hit;  // [R07]
      txh_r      <= thr_bus.tx_hit;  // [R08]
    end
  end

  assign REG_RDATA  = rdata_r;
  assign PIN_OUT    = out_r;
  assign PIN_OE     = oe_r;
  assign PIN_DS     = ds_r;
  assign RX_THR_HIT = rxh_r;
  assign TX_THR_HIT = txh_r;
  assign TEST_SETTING_ONE_VAL  = test_setting_one_r;
  assign TEST_SETTING_TWO_VAL  = test_setting_two_r;

  // ==========================================
  // assertions
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  property p_inv_rx;
    CE && pin_cfg_r[0][5:0] == `PFC_FN_RXTHR |=>
      PIN_OUT[0] == ($past(rxh_r) ^ $past(pin_cfg_r[0][6])) && PIN_OE[0];
  endproperty
  a_inv_rx: assert property (p_inv_rx) else $error("pin 0 invert wrong");  // [R01]

  property p_pin1_hiz;
    !$past(RST_B) |-> pin_cfg_r[1][5:0] == `PFC_FN_HIZ ##1 !PIN_OE[1];
  endproperty
  a_pin1_hiz: assert property (p_pin1_hiz) else $error("pin 1 not idle at reset");  // [R02]

  property p_xdiv;
    CE && xdiv_cnt_r == 7'h5f |=> xdiv_cnt_r == 7'h00 && xclk_r != $past(xclk_r);
  endproperty
  a_xdiv: assert property (p_xdiv) else $error("divider half period wrong");  // [R03]

  property p_ds;
    CE |=> PIN_DS == $past(pin_cfg_r[1][7]);
  endproperty
  a_ds: assert property (p_ds) else $error("drive strength not following");  // [R05]

  property p_wake;
    CE && WAKE |=> (TEST_SETTING_ONE_VAL == ($past(thr_cfg_r[6]) ? 8'h35 : 8'h31))
                && (TEST_SETTING_TWO_VAL == ($past(thr_cfg_r[6]) ? 8'h81 : 8'h88));
  endproperty
  a_wake: assert property (p_wake) else $error("wake test setting wrong");  // [R06]

  property p_rx_thr;
    CE |=> RX_THR_HIT == ($past(RX_BYTES) >= ({1'b0, $past(thr_cfg_r[3:0]), 2'b00} + 7'h04));
  endproperty
  a_rx_thr: assert property (p_rx_thr) else $error("rx threshold wrong");  // [R07]

  property p_tx_thr;
    CE |=> TX_THR_HIT == ($past(TX_BYTES) >= (7'h3d - {1'b0, $past(thr_cfg_r[3:0]), 2'b00}));
  endproperty
  a_tx_thr: assert property (p_tx_thr) else $error("tx threshold wrong");  // [R08]

  c_wake_ret: cover property (CE && WAKE && thr_cfg_r[6]);
  c_xclk:     cover property (PIN_OE[0] && $rose(PIN_OUT[0]));
  c_rx_hit:   cover property ($rose(RX_THR_HIT));
  c_tx_hit:   cover property ($rose(TX_THR_HIT) && thr_cfg_r[3:0] == 4'hf);
endmodule : pfc_top

// *** verif/pfc_host.sv ***
`timescale 1ns/100ps
`include "pfc_cfg.svh"
module pfc_host (
  // register port
  input  wire logic                CLOCK,
  input  wire pfc_pkg::pfc_byte_t  REG_RDATA,
  output      pfc_pkg::pfc_addr_t  REG_ADDR,
  output      logic                REG_WR,
  output      logic                REG_RD,
  output      pfc_pkg::pfc_byte_t  REG_WDATA
);
  import pfc_pkg::*;
  // ==========================================
  // bus cycles
  initial begin
    REG_ADDR  = 6'h00;
    REG_WR    = 1'b0;
    REG_RD    = 1'b0;
    REG_WDATA = 8'h00;
  end
  task automatic wr(input pfc_addr_t a, input pfc_byte_t d);
    @(negedge CLOCK);
    REG_ADDR  = a;
    REG_WDATA = d;
    REG_WR    = 1'b1;
    @(negedge CLOCK);
    REG_WR    = 1'b0;
    // released data never keeps the last value
    REG_WDATA = ~d;
  endtask : wr
  task automatic rd(input pfc_addr_t a, output pfc_byte_t d);
    @(negedge CLOCK);
    REG_ADDR = a;
    REG_RD   = 1'b1;
    @(negedge CLOCK);
    REG_RD = 1'b0;
    @(negedge CLOCK);
    d = REG_RDATA;
  endtask : rd
  // divided clock off for quieter radio
  task automatic init_off();
    wr(`PFC_ADDR_PIN0, {2'b00, `PFC_FN_HIZ});
  endtask : init_off
endmodule : pfc_host

// *** verif/pfc_top_tb.sv ***
`timescale 1ns/100ps
`include "pfc_cfg.svh"
module pfc_top_tb;
  import pfc_pkg::*;
  logic       clock;
  logic       rst_b;
  logic       ce;
  logic       wake;
  pfc_addr_t  reg_addr;
  logic       reg_wr;
  logic       reg_rd;
  pfc_byte_t  reg_wdata;
  pfc_byte_t  reg_rdata;
  pfc_cnt_t   rx_bytes;
  pfc_cnt_t   tx_bytes;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic       pin_ds;
  logic       rx_hit;
  logic       tx_hit;
  pfc_byte_t  test_setting_one;
  pfc_byte_t  test_setting_two;
  pfc_byte_t  v;
  int         err_count;
  int         checked;
  int         n;
  pfc_top DUT (.CLOCK(clock), .RST_B(rst_b), .CE(ce), .REG_ADDR(reg_addr),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .RX_BYTES(rx_bytes), .TX_BYTES(tx_bytes), .WAKE(wake), .PIN_OUT(pin_out),
    .PIN_OE(pin_oe), .PIN_DS(pin_ds), .RX_THR_HIT(rx_hit), .TX_THR_HIT(tx_hit),
    .TEST_SETTING_ONE_VAL(test_setting_one), .TEST_SETTING_TWO_VAL(test_setting_two));
  pfc_host u_host (.CLOCK(clock), .REG_RDATA(reg_rdata), .REG_ADDR(reg_addr),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata));
  // ==========================================
  // helpers
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic chk(input pfc_byte_t seen, input pfc_byte_t exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("compares %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic step(input int c);
    repeat (c) @(negedge clock);
  endtask : step
  // bounded wait for the next pin 0 edge
  task automatic wait_tog(output int c);
    logic l;
    l = pin_out[0];
    c = 0;
    while (pin_out[0] === l) begin
      @(negedge clock);
      c++;
      if (c > 300) begin
        err_count++;
        conclude();
      end
    end
  endtask : wait_tog
  // ==========================================
  // scenarios
  task automatic t_reset();
    u_host.rd(`PFC_ADDR_PIN1, v);
    chk(v, 8'h2e);
    u_host.rd(`PFC_ADDR_PIN0, v);
    chk(v, 8'h3f);
    u_host.rd(`PFC_ADDR_THR, v);
    chk(v, 8'h07);
    u_host.rd(6'h04, v);
    chk(v, 8'h00);
    chk(8'(pin_oe), 8'h01);
    $display("test reset done");
  endtask : t_reset
  task automatic t_div();
    wait_tog(n);
    wait_tog(n);
    chk(8'(n), 8'h60);
    u_host.init_off();
    step(3);
    chk(8'(pin_oe), 8'h00);
    $display("test divider done");
  endtask : t_div
  task automatic t_pins();
    u_host.wr(`PFC_ADDR_PIN1, 8'hee);
    step(3);
    chk(8'(pin_ds), 8'h01);
    chk(8'(pin_oe[1]), 8'h00);
    chk(8'(pin_out[1]), 8'h01);
    u_host.wr(`PFC_ADDR_PIN1, 8'h40);
    step(3);
    chk(8'(pin_ds), 8'h00);
    chk(8'(pin_out[1]), 8'h01);
    $display("test pins done");
  endtask : t_pins
  // each setting at its exact boundary, one byte below then at it
  task automatic t_thr();
    // pin 0 shows the inverted rx hit, pin 1 the plain tx hit
    u_host.wr(`PFC_ADDR_PIN0, 8'h40);
    u_host.wr(`PFC_ADDR_PIN1, 8'h02);
    for (int s = 0; s < 16; s++) begin
      u_host.wr(`PFC_ADDR_THR, 8'(s));
      rx_bytes = 7'(4 * (s + 1) - 1);
      tx_bytes = 7'(61 - 4 * s - 1);
      step(3);
      chk(8'(rx_hit), 8'h00);
      chk(8'(tx_hit), 8'h00);
      chk(8'(pin_out[0]), 8'h01);
      chk(8'(pin_out[1]), 8'h00);
      rx_bytes = 7'(4 * (s + 1));
      tx_bytes = 7'(61 - 4 * s);
      step(3);
      chk(8'(rx_hit), 8'h01);
      chk(8'(tx_hit), 8'h01);
      chk(8'(pin_out[0]), 8'h00);
      chk(8'(pin_out[1]), 8'h01);
    end
    $display("test thresholds done");
  endtask : t_thr
  task automatic t_wake();
    u_host.wr(`PFC_ADDR_THR, 8'h47);
    step(2);
    chk(test_setting_one, 8'h31);
    for (int r = 1; r >= 0; r--) begin
      u_host.wr(`PFC_ADDR_THR, {1'b0, 1'(r), 6'h07});
      wake = 1'b1;
      step(1);
      wake = 1'b0;
      step(1);
      chk(test_setting_one, r ? 8'h35 : 8'h31);
      chk(test_setting_two, r ? 8'h81 : 8'h88);
    end
    $display("test wake done");
  endtask : t_wake
  // writes and wake while frozen must leave no trace
  task automatic t_ce();
    u_host.wr(`PFC_ADDR_THR, 8'h47);
    ce = 1'b0;
    u_host.wr(`PFC_ADDR_PIN1, 8'h80);
    wake = 1'b1;
    step(1);
    wake = 1'b0;
    step(2);
    ce = 1'b1;
    step(2);
    chk(test_setting_one, 8'h31);
    chk(8'(pin_ds), 8'h00);
    u_host.rd(`PFC_ADDR_PIN1, v);
    chk(v, 8'h02);
    $display("test enable done");
  endtask : t_ce
  // ==========================================
  // main sequence
  initial begin
    err_count = 0;
    checked   = 0;
    rst_b     = 1'b0;
    ce        = 1'b1;
    wake      = 1'b0;
    rx_bytes  = 7'h00;
    tx_bytes  = 7'h00;
    step(20);
    rst_b = 1'b1;
    t_reset();
    t_div();
    t_pins();
    t_thr();
    t_wake();
    t_ce();
    conclude();
  end
endmodule : pfc_top_tb
